/* File: common/wpc_pkg.sv */
// Package: constants, enums and carrier structs for waveform parameter control
package wpc_pkg;
  // Function selection codes
  typedef enum logic [2:0] {
    WPC_FN_SINE  = 3'h0,
    WPC_FN_SQR   = 3'h1,
    WPC_FN_TRI   = 3'h2,
    WPC_FN_RAMP  = 3'h3,
    WPC_FN_NOISE = 3'h4,
    WPC_FN_ARB   = 3'h5
  } wpc_func_t;

  // Modulation type codes
  typedef enum logic [2:0] {
    WPC_MOD_LIN   = 3'h0,
    WPC_MOD_LOG   = 3'h1,
    WPC_MOD_AM    = 3'h2,
    WPC_MOD_FM    = 3'h3,
    WPC_MOD_PM    = 3'h4,
    WPC_MOD_BURST = 3'h5
  } wpc_mod_t;

  // Amplitude display unit
  typedef enum logic [1:0] {
    WPC_U_VPP  = 2'h0,
    WPC_U_VRMS = 2'h1,
    WPC_U_DBM  = 2'h2
  } wpc_unit_t;

  // Frequency display resolution
  typedef enum logic [1:0] {
    WPC_DISP_MILLI = 2'h0,
    WPC_DISP_MICRO = 2'h1,
    WPC_DISP_NOISE = 2'h2
  } wpc_disp_t;

  // Register map (word offsets = byte address, 32-bit words)
  localparam logic [7:0] WPC_A_CTRL   = 8'h00;
  localparam logic [7:0] WPC_A_FREQUENCY_KEY_L = 8'h04;
  localparam logic [7:0] WPC_A_FREQUENCY_KEY_H = 8'h08;
  localparam logic [7:0] WPC_A_STEP_L = 8'h0C;
  localparam logic [7:0] WPC_A_STEP_H = 8'h10;
  localparam logic [7:0] WPC_A_AMPLITUDE_KEY   = 8'h14;
  localparam logic [7:0] WPC_A_OFFS   = 8'h18;
  localparam logic [7:0] WPC_A_PHASE  = 8'h1C;
  localparam logic [7:0] WPC_A_ARBDIV = 8'h20;
  localparam logic [7:0] WPC_A_CMD    = 8'h24;
  localparam logic [7:0] WPC_A_STAT   = 8'h28;
  localparam logic [7:0] WPC_A_ARBLEN = 8'h2C;

  // CTRL fields
  localparam int WPC_C_FUNC  = 0;  // [2:0]
  localparam int WPC_C_MODT  = 4;  // [6:4]
  localparam int WPC_C_MODEN = 8;
  localparam int WPC_C_INV   = 9;
  localparam int WPC_C_UNIT  = 12; // [13:12]
  localparam int WPC_C_MODBAD = 16;

  // CMD bits (write one to act)
  localparam int WPC_K_UP   = 0;
  localparam int WPC_K_DOWN = 1;
  localparam int WPC_K_TTL  = 2;
  localparam int WPC_K_ECL  = 3;
  localparam int WPC_K_ZERO = 4;
  localparam int WPC_K_INVSEL = 5;
  localparam int WPC_K_CLRERR = 6;

  // STAT bits
  localparam int WPC_S_FERR  = 0;
  localparam int WPC_S_MERR  = 1;
  localparam int WPC_S_REJ   = 2;
  localparam int WPC_S_NOPH  = 3;
  localparam int WPC_S_NOAC  = 4;
  localparam int WPC_S_DISP  = 8;  // [9:8]
  localparam int WPC_S_RES   = 12; // [15:12] digit exponent

  // Frequency in microhertz, 48 bits
  localparam int WPC_FW = 48;
  localparam logic [47:0] WPC_FMAX_SQ  = 48'h1B77_C9B1_B000; // 30.2 MHz
  localparam logic [47:0] WPC_FMAX_TR  = 48'h0017_4876_E800; // 100 kHz
  localparam logic [47:0] WPC_F_1MHZ   = 48'h00E8_D4A5_1000;
  localparam logic [47:0] WPC_F_MILLI  = 48'h0000_0000_03E8;
  localparam logic [47:0] WPC_F_RST    = 48'h00E8_D4A5_1000; // 1 MHz

  // Voltages in millivolts, signed 16 bit; amplitude is peak-to-peak
  localparam logic [15:0] WPC_V_LIM    = 16'h1388; // 5 V
  localparam logic [15:0] WPC_V_TTL_A  = 16'h1388; // 5 Vpp
  localparam logic [15:0] WPC_V_TTL_O  = 16'h09C4; // 2.5 V
  localparam logic [15:0] WPC_V_ECL_A  = 16'h03E8; // 1 Vpp
  localparam logic [15:0] WPC_V_ECL_O  = 16'hFAEC; // -1.3 V
  localparam logic [15:0] WPC_V_RST_A  = 16'h03E8;

  // Phase in millidegrees, signed 32 bit
  localparam logic [31:0] WPC_PH_MAX   = 32'h006D_DCFF; // 7199.999 deg
  localparam logic [31:0] WPC_PH_MIN   = 32'hFF92_2301;

  // Sync pulse timing
  localparam int WPC_CLK_MHZ   = 200;
  localparam int WPC_SYNC_NS   = 25;
  localparam int WPC_SYNC_CYC  = (WPC_SYNC_NS * WPC_CLK_MHZ + 999) / 1000;

  // Register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } wpc_bus_t;

  // Settings applied to the synthesis core and output stage
  typedef struct packed {
    logic [2:0]  func;
    logic [47:0] frequency_key;
    logic [33:0] arb_div;
    logic [15:0] amplitude_key;
    logic [15:0] offs;
    logic [31:0] phase;
    logic        ac_on;
    logic        invert;
    logic        mod_en;
  } wpc_core_t;
endpackage

/* File: hw/wpc_top.sv */
// Waveform parameter control: validation, presets, arb stepping and sync
`timescale 1ns/100ps
module wpc_top #(
  parameter int ARB_AW = 12  // Address width of waveform point counter
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [7:0]          bus_addr,
  input  wire logic [31:0]         bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic      [31:0]         bus_rdata,
  output wpc_pkg::wpc_core_t       core,
  output logic      [ARB_AW-1:0]   arb_point,
  output logic                     sync_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Frequency ceiling per function; noise, arb and unused codes fall back to the sine/square ceiling
  function automatic logic [47:0] fmax(input logic [2:0] f);
    unique case (f)
      wpc_pkg::WPC_FN_SINE, wpc_pkg::WPC_FN_SQR: fmax = wpc_pkg::WPC_FMAX_SQ;
      wpc_pkg::WPC_FN_TRI, wpc_pkg::WPC_FN_RAMP: fmax = wpc_pkg::WPC_FMAX_TR;
      default:                                   fmax = wpc_pkg::WPC_FMAX_SQ;
    endcase
  endfunction

  // Magnitude of a signed millivolt value
  function automatic logic [15:0] vabs(input logic [15:0] v);
    vabs = v[15] ? 16'(-v) : v;
  endfunction

  // Peak (half of peak-to-peak) plus |offset| within limit
  function automatic logic fits(input logic [15:0] a, input logic [15:0] o);
    logic [16:0] s;
    s = {2'h0, a[15:1]} + {1'h0, vabs(o)};
    fits = (s <= {1'h0, wpc_pkg::WPC_V_LIM}) && !o[15] | (s <= {1'h0,
           wpc_pkg::WPC_V_LIM});
  endfunction

  // Modulation legal for a function
  function automatic logic mod_ok(input logic [2:0] f, input logic [2:0] m);
    if (f == wpc_pkg::WPC_FN_NOISE) mod_ok = 1'b0;
    else if (f == wpc_pkg::WPC_FN_ARB)
      mod_ok = (m == wpc_pkg::WPC_MOD_AM) || (m == wpc_pkg::WPC_MOD_BURST);
    else mod_ok = 1'b1;
  endfunction

  // Decimal exponent of a millivolt magnitude's leading digit
  function automatic logic [3:0] dexp(input logic [15:0] v);
    if (v >= 16'h2710) dexp = 4'h4;
    else if (v >= 16'h03E8) dexp = 4'h3;
    else if (v >= 16'h0064) dexp = 4'h2;
    else if (v >= 16'h000A) dexp = 4'h1;
    else dexp = 4'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [2:0]  func_q;      // Selected function
  logic [2:0]  modt_q;      // Modulation type
  logic        moden_q;     // Modulation enable
  logic        modbad_q;    // Host flags parameters as conflicting
  logic        inv_q;       // Inversion enable
  logic        invsel_q;    // Adjust keys act on inversion
  logic [1:0]  unit_q;      // Display unit only
  logic [47:0] frequency_key_q;      // Standard function frequency, uHz
  logic [47:0] step_q;      // Adjust step
  logic [15:0] amplitude_key_q;      // Peak-to-peak, mV
  logic [15:0] offs_q;      // Offset, mV signed
  logic [31:0] phase_q;     // Entered phase, mdeg
  logic [31:0] phref_q;     // Zero reference
  logic [33:0] div_q;       // Arb divider N
  logic [ARB_AW-1:0] arblen_q; // Last point index
  logic        ferr_q, merr_q, rej_q, noph_q;
  logic [31:0] rdata_q;

  wire wpc_pkg::wpc_bus_t req = '{wr: bus_wr, rd: bus_rd, addr: bus_addr,
                                  wdata: bus_wdata};
  wire logic       cmd_wr   = req.wr && req.addr == wpc_pkg::WPC_A_CMD;
  wire logic [2:0] wfunc    = req.wdata[wpc_pkg::WPC_C_FUNC +: 3];
  wire logic [2:0] wmodt    = req.wdata[wpc_pkg::WPC_C_MODT +: 3];
  wire logic       fn_chg   = req.wr && req.addr == wpc_pkg::WPC_A_CTRL
                              && wfunc != func_q;
  wire logic       wbad     = req.wdata[wpc_pkg::WPC_C_MODBAD];
  // Phase lock condition
  wire logic       ph_lock  = func_q == wpc_pkg::WPC_FN_NOISE
                           || func_q == wpc_pkg::WPC_FN_ARB
                           || (moden_q && (modt_q == wpc_pkg::WPC_MOD_LIN
                               || modt_q == wpc_pkg::WPC_MOD_LOG
                               || modt_q == wpc_pkg::WPC_MOD_FM
                               || modt_q == wpc_pkg::WPC_MOD_PM));
  wire logic       inv_ok   = func_q == wpc_pkg::WPC_FN_RAMP
                           || func_q == wpc_pkg::WPC_FN_ARB;
  wire logic       is_noise = func_q == wpc_pkg::WPC_FN_NOISE;
  wire logic [47:0] fup     = frequency_key_q + step_q;
  wire logic [47:0] fdn     = frequency_key_q - step_q;
  wire logic        up_k    = cmd_wr && req.wdata[wpc_pkg::WPC_K_UP];
  wire logic        dn_k    = cmd_wr && req.wdata[wpc_pkg::WPC_K_DOWN];
  wire logic [47:0] wfreq   = {req.wdata[15:0], frequency_key_q[31:0]};
  wire logic [31:0] wphase  = req.wdata;
  wire logic        ph_inr  = $signed(wphase) <= $signed(wpc_pkg::WPC_PH_MAX)
                           && $signed(wphase) >= $signed(wpc_pkg::WPC_PH_MIN);
  // Arb rate request: host writes desired N times two (one fraction bit)
  wire logic [34:0] div_rnd = 35'({1'b0, req.wdata} + 33'h1) >> 1;

  ////////////////////////////////////////////////////////////////////////////
  // Settings register file and validation
  always_ff @(posedge mclk) begin
    if (rst) begin
      func_q <= 3'h0; modt_q <= 3'h2; moden_q <= 1'b0; modbad_q <= 1'b0;
      inv_q <= 1'b0; invsel_q <= 1'b0; unit_q <= 2'h0;
      frequency_key_q <= wpc_pkg::WPC_F_RST; step_q <= wpc_pkg::WPC_F_MILLI;
      amplitude_key_q <= wpc_pkg::WPC_V_RST_A; offs_q <= 16'h0000;
      phase_q <= 32'h0000_0000; phref_q <= 32'h0000_0000;
      div_q <= 34'h1; arblen_q <= '1;
      ferr_q <= 1'b0; merr_q <= 1'b0; rej_q <= 1'b0; noph_q <= 1'b0;
    end else begin
      // Error flags clear first so a same-cycle event wins
      if (cmd_wr && req.wdata[wpc_pkg::WPC_K_CLRERR]) begin
        ferr_q <= 1'b0; merr_q <= 1'b0; rej_q <= 1'b0; noph_q <= 1'b0;
      end
      if (req.wr) begin
        unique case (req.addr)
          wpc_pkg::WPC_A_CTRL: begin
            func_q   <= wfunc;       // Amplitude untouched
            modt_q   <= wmodt;
            modbad_q <= wbad;
            unit_q   <= req.wdata[wpc_pkg::WPC_C_UNIT +: 2];
            if (fn_chg && wfunc != wpc_pkg::WPC_FN_NOISE
                && wfunc != wpc_pkg::WPC_FN_ARB && frequency_key_q > fmax(wfunc)) begin
              frequency_key_q <= fmax(wfunc);
              ferr_q <= 1'b1;
            end
            if (fn_chg && moden_q && (!mod_ok(wfunc, wmodt) || wbad)) begin
              moden_q <= 1'b0;
              merr_q  <= 1'b1;
            end else if (req.wdata[wpc_pkg::WPC_C_MODEN]
                         && !(mod_ok(wfunc, wmodt) && !wbad)) begin
              moden_q <= 1'b0;
              merr_q  <= 1'b1;
            end else begin
              moden_q <= req.wdata[wpc_pkg::WPC_C_MODEN];
            end
            if (!(wfunc == wpc_pkg::WPC_FN_RAMP
                  || wfunc == wpc_pkg::WPC_FN_ARB))
              inv_q <= 1'b0;
          end
          wpc_pkg::WPC_A_FREQUENCY_KEY_L, wpc_pkg::WPC_A_FREQUENCY_KEY_H: begin
            if (is_noise) rej_q <= 1'b1;
            else if (req.addr == wpc_pkg::WPC_A_FREQUENCY_KEY_L)
              frequency_key_q <= {frequency_key_q[47:32], req.wdata};
            else if (wfreq > fmax(func_q)) rej_q <= 1'b1;
            else frequency_key_q <= wfreq;
          end
          wpc_pkg::WPC_A_STEP_L: step_q <= {step_q[47:32], req.wdata};
          wpc_pkg::WPC_A_STEP_H: step_q <= {req.wdata[15:0], step_q[31:0]};
          wpc_pkg::WPC_A_AMPLITUDE_KEY: begin
            if (fits(req.wdata[15:0], offs_q)) amplitude_key_q <= req.wdata[15:0];
            else rej_q <= 1'b1;
          end
          wpc_pkg::WPC_A_OFFS: begin
            if (vabs(req.wdata[15:0]) <= wpc_pkg::WPC_V_LIM
                && fits(amplitude_key_q, req.wdata[15:0]))
              offs_q <= req.wdata[15:0];
            else rej_q <= 1'b1;
          end
          wpc_pkg::WPC_A_PHASE: begin
            if (ph_lock) noph_q <= 1'b1;
            else if (ph_inr) phase_q <= wphase;
            else rej_q <= 1'b1;
          end
          wpc_pkg::WPC_A_ARBDIV: begin
            if (div_rnd[33:0] == 34'h0) div_q <= 34'h1;
            else div_q <= div_rnd[33:0];
          end
          wpc_pkg::WPC_A_ARBLEN: arblen_q <= req.wdata[ARB_AW-1:0];
          wpc_pkg::WPC_A_CMD: begin
            if (req.wdata[wpc_pkg::WPC_K_INVSEL])
              invsel_q <= ~invsel_q;
            if (req.wdata[wpc_pkg::WPC_K_TTL]) begin
              amplitude_key_q <= wpc_pkg::WPC_V_TTL_A;
              offs_q <= wpc_pkg::WPC_V_TTL_O;
            end
            if (req.wdata[wpc_pkg::WPC_K_ECL]) begin
              amplitude_key_q <= wpc_pkg::WPC_V_ECL_A;
              offs_q <= wpc_pkg::WPC_V_ECL_O;
            end
            if (req.wdata[wpc_pkg::WPC_K_ZERO]) begin
              phref_q <= 32'(phref_q + phase_q);
              phase_q <= 32'h0000_0000;
            end
            if (invsel_q && inv_ok && (up_k || dn_k))
              inv_q <= up_k;
            else if (!invsel_q && is_noise && (up_k || dn_k))
              rej_q <= 1'b1;
            else if (!invsel_q && up_k && fup <= fmax(func_q)
                     && fup > frequency_key_q)
              frequency_key_q <= fup;
            else if (!invsel_q && dn_k && frequency_key_q > step_q)
              frequency_key_q <= fdn;
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display helpers
  wire logic [1:0] disp_w = is_noise ? wpc_pkg::WPC_DISP_NOISE
                    : (frequency_key_q < wpc_pkg::WPC_F_1MHZ
                       && (frequency_key_q % wpc_pkg::WPC_F_MILLI) != 48'h0)
                      ? wpc_pkg::WPC_DISP_MICRO : wpc_pkg::WPC_DISP_MILLI;
  wire logic [15:0] big_w = (offs_q == 16'h0) ? amplitude_key_q
                   : (amplitude_key_q == 16'h0) ? vabs(offs_q)
                   : (amplitude_key_q > vabs(offs_q)) ? amplitude_key_q : vabs(offs_q);
  // Lowest settable digit for three significant digits
  wire logic [3:0] res_w = (dexp(big_w) > 4'h2) ? 4'(dexp(big_w) - 4'h2)
                                                : 4'h0;
  wire logic noac_w = amplitude_key_q == 16'h0 && unit_q == wpc_pkg::WPC_U_DBM;

  wire logic [31:0] stat_w = 32'(ferr_q) << wpc_pkg::WPC_S_FERR
                           | 32'(merr_q) << wpc_pkg::WPC_S_MERR
                           | 32'(rej_q)  << wpc_pkg::WPC_S_REJ
                           | 32'(noph_q) << wpc_pkg::WPC_S_NOPH
                           | 32'(noac_w) << wpc_pkg::WPC_S_NOAC
                           | 32'(disp_w) << wpc_pkg::WPC_S_DISP
                           | 32'(res_w)  << wpc_pkg::WPC_S_RES;
  wire logic [31:0] ctrl_w = 32'(func_q) << wpc_pkg::WPC_C_FUNC
                           | 32'(modt_q) << wpc_pkg::WPC_C_MODT
                           | 32'(moden_q) << wpc_pkg::WPC_C_MODEN
                           | 32'(inv_q)  << wpc_pkg::WPC_C_INV
                           | 32'(unit_q) << wpc_pkg::WPC_C_UNIT
                           | 32'(modbad_q) << wpc_pkg::WPC_C_MODBAD;
  // Read mux; unmapped addresses and CMD read as zero
  wire logic [31:0] rmux = (req.addr == wpc_pkg::WPC_A_CTRL) ? ctrl_w
    : (req.addr == wpc_pkg::WPC_A_FREQUENCY_KEY_L) ? frequency_key_q[31:0]
    : (req.addr == wpc_pkg::WPC_A_FREQUENCY_KEY_H) ? {16'h0, frequency_key_q[47:32]}
    : (req.addr == wpc_pkg::WPC_A_STEP_L) ? step_q[31:0]
    : (req.addr == wpc_pkg::WPC_A_STEP_H) ? {16'h0, step_q[47:32]}
    : (req.addr == wpc_pkg::WPC_A_AMPLITUDE_KEY)   ? {16'h0, amplitude_key_q}
    : (req.addr == wpc_pkg::WPC_A_OFFS)   ? {16'h0, offs_q}
    : (req.addr == wpc_pkg::WPC_A_PHASE)  ? phase_q
    : (req.addr == wpc_pkg::WPC_A_ARBDIV) ? div_q[31:0]
    : (req.addr == wpc_pkg::WPC_A_ARBLEN) ? 32'(arblen_q)
    : (req.addr == wpc_pkg::WPC_A_STAT)   ? stat_w : 32'h0;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) rdata_q <= 32'h0;
    else rdata_q <= req.rd ? rmux : 32'h0;
  end
  assign bus_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Arb point stepping: clock enable every N master periods
  // The divider counts periods of the 200 MHz master clock directly, without prescaling
  logic [33:0]       dcnt_q;
  logic [ARB_AW-1:0] pt_q;
  logic [2:0]        scnt_q;
  logic              sync_q;
  wire logic is_arb  = func_q == wpc_pkg::WPC_FN_ARB;
  wire logic step_en = is_arb && dcnt_q >= div_q - 34'h1;
  wire logic wrap    = step_en && pt_q == arblen_q;
  wire logic sync_kill = is_noise
                      || (moden_q && modt_q == wpc_pkg::WPC_MOD_BURST);

  // Dwell one sample period per point
  always_ff @(posedge mclk) begin
    if (rst || !is_arb) begin
      dcnt_q <= 34'h0;
      pt_q   <= '0;
    end else if (step_en) begin
      dcnt_q <= 34'h0;
      pt_q   <= wrap ? '0 : ARB_AW'(pt_q + 1'b1);
    end else begin
      dcnt_q <= 34'(dcnt_q + 34'h1);
    end
  end

  // Sync: 25 ns low pulse at each pass start, suppressed high otherwise
  always_ff @(posedge mclk) begin
    if (rst) begin
      scnt_q <= 3'h0;
      sync_q <= 1'b1;
    end else if (sync_kill) begin
      scnt_q <= 3'h0;
      sync_q <= 1'b1;
    end else if (wrap) begin
      scnt_q <= 3'(wpc_pkg::WPC_SYNC_CYC - 1);
      sync_q <= 1'b0;
    end else if (scnt_q != 3'h0) begin
      scnt_q <= 3'(scnt_q - 3'h1);
    end else begin
      sync_q <= 1'b1;
    end
  end
  assign sync_n    = sync_q;
  assign arb_point = pt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Core outputs, registered; phase is relative to the timebase
  always_ff @(posedge mclk) begin
    if (rst) core <= '0;
    else begin
      core.func    <= func_q;
      core.frequency_key    <= frequency_key_q;
      core.arb_div <= div_q;
      core.amplitude_key    <= amplitude_key_q;
      core.offs    <= offs_q;
      core.phase   <= 32'(phref_q + phase_q);
      core.ac_on   <= amplitude_key_q != 16'h0;
      core.invert  <= inv_q && inv_ok;
      core.mod_en  <= moden_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sync_quiet_a: assert property (@(posedge mclk) disable iff (rst)
    sync_kill |=> sync_n) else $error("sync active while suppressed");
  // Suppression may cut a pulse short, so it stops the width check
  sync_width_a: assert property (@(posedge mclk) disable iff (rst || sync_kill)
    $fell(sync_n) && !sync_kill |-> !sync_n [*5] ##1 sync_n)
    else $error("sync pulse width wrong");
  frequency_key_clamp_a: assert property (@(posedge mclk) disable iff (rst)
    fn_chg && wfunc == wpc_pkg::WPC_FN_TRI && frequency_key_q > wpc_pkg::WPC_FMAX_TR
    |=> frequency_key_q == wpc_pkg::WPC_FMAX_TR && ferr_q)
    else $error("frequency not clamped");
  mod_off_a: assert property (@(posedge mclk) disable iff (rst)
    fn_chg && moden_q && wfunc == wpc_pkg::WPC_FN_NOISE
    |=> !moden_q && merr_q) else $error("modulation not dropped");
  noise_frequency_key_a: assert property (@(posedge mclk) disable iff (rst)
    is_noise && !fn_chg |=> $stable(frequency_key_q))
    else $error("noise frequency changed");
  amplitude_key_keep_a: assert property (@(posedge mclk) disable iff (rst)
    fn_chg |=> $stable(amplitude_key_q)) else $error("amplitude moved");
  ttl_load_a: assert property (@(posedge mclk) disable iff (rst)
    cmd_wr && req.wdata[wpc_pkg::WPC_K_TTL] && !req.wdata[wpc_pkg::WPC_K_ECL]
    |=> amplitude_key_q == wpc_pkg::WPC_V_TTL_A && offs_q == wpc_pkg::WPC_V_TTL_O)
    else $error("TTL preset not loaded");
  phase_lock_a: assert property (@(posedge mclk) disable iff (rst)
    req.wr && req.addr == wpc_pkg::WPC_A_PHASE && ph_lock
    |=> $stable(phase_q) && noph_q) else $error("phase changed");
  offs_range_a: assert property (@(posedge mclk) disable iff (rst)
    vabs(offs_q) <= wpc_pkg::WPC_V_LIM) else $error("offset too big");
endmodule

/* File: tb/wpc_host.sv */
// Host command source model driving the register port
`timescale 1ns/100ps
module wpc_host (
  input  wire logic        mclk,
  output logic      [7:0]  bus_addr,
  output logic      [31:0] bus_wdata,
  output logic             bus_wr,
  output logic             bus_rd,
  input  wire logic [31:0] bus_rdata
);
  // Idle bus from time zero
  initial begin
    bus_addr = 8'h00;
    bus_wdata = 32'h0000_0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // One-cycle write; data then toggles so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge mclk);
    bus_wr <= 1'b0;
    bus_wdata <= ~v;
  endtask
  // One-cycle read; answer only stands in the next cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask
endmodule

/* File: tb/waveform_parameter_control_bench.sv */
// Self-checking bench for waveform parameter control
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module waveform_parameter_control_bench;
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         bus_addr;
  logic [31:0]        bus_wdata, bus_rdata, d;
  logic               bus_wr, bus_rd, sync_n;
  logic [11:0]        arb_point;
  wpc_pkg::wpc_core_t core;
  int                 bad_count = 0, checks = 0, a, o, cur, n;
  always #2.5 mclk = ~mclk;
  wpc_host u_host (.mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  wpc_top u_dut (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .core(core), .arb_point(arb_point),
    .sync_n(sync_n));
  // Counts, verdict and end of run
  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Write, then wait until the core output has taken it
  task automatic put(input logic [7:0] ad, input logic [31:0] v);
    u_host.wr(ad, v);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // Offset legal when half the swing plus the offset stays within 5 V
  function automatic bit ok(int am, int of);
    return am / 2 + (of < 0 ? -of : of) <= 5000;
  endfunction
  // Watchdog sized well above the scripted run
  initial begin
    #100000;
    bad_count++;
    test_done;
  end
  initial begin
    void'($urandom(77));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(core.amplitude_key, wpc_pkg::WPC_V_RST_A)
    put(wpc_pkg::WPC_A_CMD, 32'h0000_0004);
    `CHK({core.amplitude_key, core.offs}, {wpc_pkg::WPC_V_TTL_A, wpc_pkg::WPC_V_TTL_O})
    put(wpc_pkg::WPC_A_CMD, 32'h0000_0008);
    `CHK({core.amplitude_key, core.offs}, {wpc_pkg::WPC_V_ECL_A, wpc_pkg::WPC_V_ECL_O})
    // Random swing and offset pairs, some beyond the limit
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 0 : $urandom_range(0, 10000);
      o = $urandom_range(0, 12000) - 6000;
      put(wpc_pkg::WPC_A_OFFS, 32'h0000_0000);
      put(wpc_pkg::WPC_A_AMPLITUDE_KEY, a);
      `CHK(core.ac_on, 1'(a != 0))
      cur = ok(a, o) ? o : 0;
      put(wpc_pkg::WPC_A_OFFS, o);
      `CHK(core.offs, 16'(cur))
    end
    // 25 MHz on sine, then triangle must clamp to its ceiling
    put(wpc_pkg::WPC_A_FREQUENCY_KEY_L, 32'hC41E_9000);
    put(wpc_pkg::WPC_A_FREQUENCY_KEY_H, 32'h0000_16BC);
    put(wpc_pkg::WPC_A_CTRL, 32'h0000_0002);
    `CHK(core.frequency_key, wpc_pkg::WPC_FMAX_TR)
    `CHK(core.amplitude_key, 16'(a))
    u_host.rd(wpc_pkg::WPC_A_STAT, d);
    `CHK(d[0], 1'b1)
    // AM on sine, then noise must drop it but keep its type
    put(wpc_pkg::WPC_A_CTRL, 32'h0000_0120);
    `CHK(core.mod_en, 1'b1)
    put(wpc_pkg::WPC_A_CTRL, 32'h0000_0124);
    `CHK(core.mod_en, 1'b0)
    u_host.rd(wpc_pkg::WPC_A_CTRL, d);
    `CHK(d[6:4], 3'h2)
    // Noise refuses frequency and keeps sync quiet
    put(wpc_pkg::WPC_A_FREQUENCY_KEY_L, 32'h0000_1000);
    u_host.rd(wpc_pkg::WPC_A_STAT, d);
    `CHK(d[2], 1'b1)
    `CHK(d[1], 1'b1)
    repeat (20) begin
      @(posedge mclk);
      #1;
      `CHK(sync_n, 1'b1)
    end
    // Arb with N of one: 8 points so each pass outlasts the pulse
    put(wpc_pkg::WPC_A_ARBLEN, 32'h0000_0007);
    put(wpc_pkg::WPC_A_ARBDIV, 32'h0000_0002);
    put(wpc_pkg::WPC_A_CTRL, 32'h0000_0005);
    n = 0;
    while (sync_n !== 1'b0 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    n = 0;
    while (sync_n === 1'b0 && n < 50) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK(n, wpc_pkg::WPC_SYNC_CYC)
    // Half-step rate entry rounds up to N of three; dwell three cycles
    put(wpc_pkg::WPC_A_ARBDIV, 32'h0000_0005);
    `CHK(core.arb_div, 34'h3)
    for (int k = 0; k < 2; k++) begin
      cur = arb_point;
      n = 0;
      while (arb_point == cur && n < 20) begin
        @(posedge mclk);
        #1 n++;
      end
    end
    `CHK(n, 3)
    // Burst silences sync; arb refuses phase
    put(wpc_pkg::WPC_A_CTRL, 32'h0000_0155);
    repeat (30) begin
      @(posedge mclk);
      #1;
      `CHK(sync_n, 1'b1)
    end
    put(wpc_pkg::WPC_A_PHASE, 32'h0000_0001);
    u_host.rd(wpc_pkg::WPC_A_STAT, d);
    `CHK(d[3], 1'b1)
    // Phase limit, then rebase and a relative entry
    put(wpc_pkg::WPC_A_CTRL, 32'h0000_0000);
    put(wpc_pkg::WPC_A_PHASE, wpc_pkg::WPC_PH_MAX);
    put(wpc_pkg::WPC_A_PHASE, wpc_pkg::WPC_PH_MAX + 32'h1);
    `CHK(core.phase, wpc_pkg::WPC_PH_MAX)
    put(wpc_pkg::WPC_A_CMD, 32'h0000_0010);
    put(wpc_pkg::WPC_A_PHASE, 32'h0000_03E8);
    `CHK(core.phase, wpc_pkg::WPC_PH_MAX + 32'h3E8)
    // Adjust keys step by one millihertz, then drive inversion on a ramp
    put(wpc_pkg::WPC_A_CMD, 32'h0000_0001);
    `CHK(core.frequency_key, wpc_pkg::WPC_FMAX_TR + wpc_pkg::WPC_F_MILLI)
    put(wpc_pkg::WPC_A_CMD, 32'h0000_0002);
    `CHK(core.frequency_key, wpc_pkg::WPC_FMAX_TR)
    put(wpc_pkg::WPC_A_CTRL, 32'h0000_0003);
    put(wpc_pkg::WPC_A_CMD, 32'h0000_0020);
    put(wpc_pkg::WPC_A_CMD, 32'h0000_0001);
    `CHK(core.invert, 1'b1)
    put(wpc_pkg::WPC_A_CTRL, 32'h0000_0000);
    `CHK(core.invert, 1'b0)
    test_done;
  end
endmodule
